// [inc/cascaded_timer_pkg.sv]
// Constants shared by the cascaded timer and its clock source selector
package cascaded_timer_pkg;

  // Register byte offsets (word aligned)
  localparam int         ADDR_W           = 8;
  localparam logic [7:0] OFS_LOWER_CTRL   = 8'h00;
  localparam logic [7:0] OFS_UPPER_CTRL   = 8'h04;
  localparam logic [7:0] OFS_PERIOD_LOW   = 8'h08;
  localparam logic [7:0] OFS_PERIOD_HIGH  = 8'h0C;
  localparam logic [7:0] OFS_DUTY_LOW     = 8'h10;
  localparam logic [7:0] OFS_DUTY_HIGH    = 8'h14;
  localparam logic [7:0] OFS_COUNT_STATUS = 8'h18;

  // Field positions
  localparam int SRC_LSB     = 0;
  localparam int SRC_W       = 3;
  localparam int MODE_LSB    = 0;
  localparam int MODE_W      = 2;
  localparam int RUN_BIT     = 3;
  localparam int TAP_BIT     = 4;
  localparam int INIT_BIT    = 7;
  localparam int BYTE_W      = 8;
  localparam int CNT_W       = 16;
  localparam int STAT_FF_BIT = 16;

  // Source clock select codes
  localparam logic [2:0] SRC_SLOW = 3'h0;
  localparam logic [2:0] SRC_DIV7 = 3'h1;
  localparam logic [2:0] SRC_DIV5 = 3'h2;
  localparam logic [2:0] SRC_DIV3 = 3'h3;
  localparam logic [2:0] SRC_LOW  = 3'h4;
  localparam logic [2:0] SRC_HALF = 3'h5;
  localparam logic [2:0] SRC_FULL = 3'h6;
  localparam logic [2:0] SRC_EXT  = 3'h7;

  // Operating modes
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_PWM   = 2'h2;

  // Prescaler taps, as powers of two of the high clock
  localparam int PRESC_W   = 11;
  localparam int EXP_SLOW  = 11;
  localparam int EXP_7     = 7;
  localparam int EXP_5     = 5;
  localparam int EXP_3     = 3;
  localparam int EXP_HALF  = 1;
  localparam int LOW_EXP   = 3;
  localparam int SYNC_PINS = 2;

  // Reset values
  localparam logic [2:0]  RST_SRC   = 3'h0;
  localparam logic [1:0]  RST_MODE  = 2'h0;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [15:0] CNT_TOP   = 16'hFFFF;
  localparam logic [15:0] CNT_ONE   = 16'h0001;

  // Bus encodings
  localparam logic [2:0] SIZE_WORD  = 3'h2;
  localparam int         HTRANS_ACT = 1;
  localparam logic       HRESP_OKAY = 1'b0;

  // Core clock rate
  localparam int CORE_CLK_HZ = 50_000_000;

endpackage

// [core/tick_source.sv]
// Count-enable source: prescaler, low clock divider, event pin edges
`timescale 1ns/10ps
module tick_source
  import cascaded_timer_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       low_clock,
  input  wire logic       external_event_input,
  input  wire logic       low_speed_mode,
  input  wire logic       divider_tap_select,
  input  wire logic [1:0] mode,
  input  wire logic [2:0] src_sel,
  output logic            tick
);

  logic [PRESC_W-1:0]   presc;
  logic [LOW_EXP-1:0]   low_div;
  logic [SYNC_PINS-1:0] pin_raw;
  logic [SYNC_PINS-1:0] pin_s1;
  logic [SYNC_PINS-1:0] pin_s2;
  logic [SYNC_PINS-1:0] pin_s3;

  assign pin_raw = {external_event_input, low_clock};

  // Two stages per pin, a third only for edge detection
  genvar g;
  generate
    for (g = 0; g < SYNC_PINS; g++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          pin_s1[g] <= 1'b0;
          pin_s2[g] <= 1'b0;
          pin_s3[g] <= 1'b0;
        end else if (ce) begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
        end
      end
    end
  endgenerate

  wire low_rise = pin_s2[0] & ~pin_s3[0];
  wire ext_fall = ~pin_s2[1] & pin_s3[1];
  wire low_div8 = low_rise & (&low_div);
  wire tap11    = &presc[EXP_SLOW-1:0];
  wire tap7     = &presc[EXP_7-1:0];
  wire tap5     = &presc[EXP_5-1:0];
  wire tap3     = &presc[EXP_3-1:0];
  wire tap1     = &presc[EXP_HALF-1:0];
  wire is_pwm   = (mode == MODE_PWM);
  wire is_event = (mode == MODE_EVENT);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      presc   <= '0;
      low_div <= '0;
    end else if (ce) begin
      presc <= presc + PRESC_W'(1);
      if (low_rise) begin
        low_div <= low_div + LOW_EXP'(1);
      end
    end
  end

  // Slowest tap falls to low clock / 8 on tap select or low speed
  wire slow_tick = (divider_tap_select | low_speed_mode) ? low_div8 : tap11;
  // Fast high clock taps are missing in low-speed modes
  wire hs_tick   = (src_sel == SRC_DIV7) ? tap7 :
                   (src_sel == SRC_DIV5) ? tap5 :
                   (src_sel == SRC_DIV3) ? tap3 : 1'b0;
  wire pwm_hs    = (src_sel == SRC_HALF) ? tap1 :
                   (src_sel == SRC_FULL) ? 1'b1 : 1'b0;
  wire pwm_any   = (src_sel == SRC_LOW) ? low_rise :
                   (src_sel == SRC_EXT) ? ext_fall : 1'b0;
  wire base_tick = (src_sel == SRC_SLOW) ? slow_tick :
                   low_speed_mode ? 1'b0 : hs_tick;

  assign tick = is_event ? ext_fall :
                (base_tick | (is_pwm & (pwm_any |
                 (~low_speed_mode & pwm_hs))));

endmodule // tick_source

// [core/cascaded_16bit_timer_pwm.sv]
// Cascaded 16-bit interval timer, event counter and PWM with AHB-Lite
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module cascaded_16bit_timer_pwm
  import cascaded_timer_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        low_clock,
  input  wire logic        external_event_input,
  input  wire logic        low_speed_mode,
  output logic             match_interrupt,
  output logic             pwm_output_pin
);

  import cascaded_timer_pkg::*;

  // Bus data-phase state
  logic              ph_write;
  logic [ADDR_W-1:0] ph_addr;

  // Software-visible control
  logic [SRC_W-1:0]  src_sel;
  logic [MODE_W-1:0] mode;
  logic              run_bit;
  logic              divider_tap_select;
  logic              flip_flop_initial_value;
  logic [CNT_W-1:0]  period_compare;
  logic [CNT_W-1:0]  duty_buffer;
  logic [CNT_W-1:0]  duty_active;

  // Counting state
  logic [CNT_W-1:0]  count;
  logic              output_toggle_flip_flop;
  logic              match_pulse;
  logic              tick;

  // Read packing
  logic [31:0]       rd_lower;
  logic [31:0]       rd_upper;
  logic [31:0]       rd_status;
  logic [31:0]       rd_value;

  // Address phase and write strobes
  wire take      = hsel & hready & htrans[HTRANS_ACT];
  wire take_word = take & (hsize == SIZE_WORD);
  wire take_rd   = take_word & ~hwrite;

  wire wr_lower  = ph_write & (ph_addr == OFS_LOWER_CTRL);
  wire wr_upper  = ph_write & (ph_addr == OFS_UPPER_CTRL);
  wire wr_per_lo = ph_write & (ph_addr == OFS_PERIOD_LOW);
  wire wr_per_hi = ph_write & (ph_addr == OFS_PERIOD_HIGH);
  wire wr_dut_lo = ph_write & (ph_addr == OFS_DUTY_LOW);
  wire wr_dut_hi = ph_write & (ph_addr == OFS_DUTY_HIGH);

  wire [BYTE_W-1:0] wbyte   = hwdata[BYTE_W-1:0];
  wire              new_run = hwdata[RUN_BIT];
  wire              new_ini = hwdata[INIT_BIT];

  // Frozen clock enable also stalls the bus, so no transfer is lost
  assign hreadyout = ce;
  assign hresp     = HRESP_OKAY;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ph_write <= 1'b0;
      ph_addr  <= '0;
    end else if (ce && hready) begin
      ph_write <= take_word & hwrite;
      ph_addr  <= haddr[ADDR_W-1:0];
    end
  end

  // Read value taken in the address phase, zero for unmapped offsets
  always_comb begin
    rd_lower  = '0;
    rd_upper  = '0;
    rd_status = '0;
    rd_lower[SRC_LSB +: SRC_W]   = src_sel;
    rd_upper[MODE_LSB +: MODE_W] = mode;
    rd_upper[RUN_BIT]            = run_bit;
    rd_upper[TAP_BIT]            = divider_tap_select;
    rd_upper[INIT_BIT]           = flip_flop_initial_value;
    rd_status[CNT_W-1:0]         = count;
    rd_status[STAT_FF_BIT]       = output_toggle_flip_flop;
  end

  // Duty reads show the active value during output
  wire [31:0] rd_duty_lo = {24'h000000, duty_active[BYTE_W-1:0]};
  wire [31:0] rd_duty_hi = {24'h000000, duty_active[CNT_W-1:BYTE_W]};
  wire [31:0] rd_per_lo  = {24'h000000, period_compare[BYTE_W-1:0]};
  wire [31:0] rd_per_hi  = {24'h000000, period_compare[CNT_W-1:BYTE_W]};

  wire [ADDR_W-1:0] ra = haddr[ADDR_W-1:0];
  assign rd_value = (ra == OFS_LOWER_CTRL)   ? rd_lower   :
                    (ra == OFS_UPPER_CTRL)   ? rd_upper   :
                    (ra == OFS_PERIOD_LOW)   ? rd_per_lo  :
                    (ra == OFS_PERIOD_HIGH)  ? rd_per_hi  :
                    (ra == OFS_DUTY_LOW)     ? rd_duty_lo :
                    (ra == OFS_DUTY_HIGH)    ? rd_duty_hi :
                    (ra == OFS_COUNT_STATUS) ? rd_status  : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (ce && take_rd) begin
      hrdata <= rd_value;
    end
  end

  // Control registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      src_sel <= RST_SRC;
    end else if (ce && wr_lower) begin
      src_sel <= wbyte[SRC_LSB +: SRC_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode                    <= RST_MODE;
      run_bit                 <= 1'b0;
      divider_tap_select      <= 1'b0;
      flip_flop_initial_value <= 1'b0;
    end else if (ce && wr_upper) begin
      mode                    <= wbyte[MODE_LSB +: MODE_W];
      run_bit                 <= new_run;
      divider_tap_select      <= wbyte[TAP_BIT];
      flip_flop_initial_value <= new_ini;
    end
  end

  // Period compare: writes land at once, no shadow copy
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      period_compare <= RST_WORD;
    end else if (ce) begin
      if (wr_per_lo) begin
        period_compare[BYTE_W-1:0] <= wbyte;
      end
      if (wr_per_hi) begin
        period_compare[CNT_W-1:BYTE_W] <= wbyte;
      end
    end
  end

  // Duty buffer, written byte by byte by software
  logic [CNT_W-1:0] next_duty_buffer;
  always_comb begin
    next_duty_buffer = duty_buffer;
    if (wr_dut_lo) begin
      next_duty_buffer[BYTE_W-1:0] = wbyte;
    end
    if (wr_dut_hi) begin
      next_duty_buffer[CNT_W-1:BYTE_W] = wbyte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      duty_buffer <= RST_WORD;
    end else if (ce) begin
      duty_buffer <= next_duty_buffer;
    end
  end

  // Count enable from the selected source
  tick_source u_tick_source (
    .core_clk             (core_clk),
    .nrst                 (nrst),
    .ce                   (ce),
    .low_clock            (low_clock),
    .external_event_input (external_event_input),
    .low_speed_mode       (low_speed_mode),
    .divider_tap_select   (divider_tap_select),
    .mode                 (mode),
    .src_sel              (src_sel),
    .tick                 (tick)
  );

  // Compare decode
  wire is_pwm     = (mode == MODE_PWM);
  wire is_cmp     = (mode == MODE_TIMER) | (mode == MODE_EVENT);
  wire step       = run_bit & tick & (is_pwm | is_cmp);
  wire [CNT_W-1:0] count_inc = count + CNT_ONE;
  // Period zero matches at count FFFF: the cycle spans the full 65536-tick range
  wire period_hit = is_cmp & (count_inc == period_compare);
  wire overflow   = is_pwm & (count == CNT_TOP);
  // Overflow wins when duty equals zero, so only one toggle happens
  wire duty_hit   = is_pwm & ~overflow & (count_inc == duty_active);
  wire cycle_end  = step & (period_hit | overflow);

  // Active duty: follows the buffer while stopped, moves at PWM cycle end
  logic [CNT_W-1:0] next_duty_active;
  always_comb begin
    next_duty_active = duty_active;
    if (!run_bit) begin
      next_duty_active = next_duty_buffer;
    end else if (cycle_end && is_pwm) begin
      next_duty_active = duty_buffer;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      duty_active <= RST_WORD;
    end else if (ce) begin
      duty_active <= next_duty_active;
    end
  end

  // Up-counter, held at zero while stopped
  logic [CNT_W-1:0] next_count;
  always_comb begin
    next_count = count;
    if (!run_bit) begin
      next_count = RST_WORD;
    end else if (cycle_end) begin
      next_count = RST_WORD;
    end else if (step) begin
      next_count = count_inc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count <= RST_WORD;
    end else if (ce) begin
      count <= next_count;
    end
  end

  // Output flop: loaded from the initial bit only by a write made
  // while stopped; the write that stops it leaves the level alone
  wire load_ini   = wr_upper & ~run_bit;
  wire toggle_ff  = step & (duty_hit | overflow);

  // Load only happens while stopped, so it never meets a toggle
  logic next_output_ff;
  always_comb begin
    next_output_ff = output_toggle_flip_flop;
    if (load_ini) begin
      next_output_ff = new_ini;
    end else if (toggle_ff) begin
      next_output_ff = ~output_toggle_flip_flop;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      output_toggle_flip_flop <= 1'b0;
    end else if (ce) begin
      output_toggle_flip_flop <= next_output_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      match_pulse <= 1'b0;
    end else if (ce) begin
      match_pulse <= cycle_end;
    end
  end

  assign match_interrupt = match_pulse;
  // Pin is the plain inverse; the port latch outside gates it
  assign pwm_output_pin  = ~output_toggle_flip_flop;

endmodule // cascaded_16bit_timer_pwm

// [tb/cascaded_timer_properties.sv]
// Port-level checker for the cascaded timer, bound to its top module
`timescale 1ns/10ps
module cascaded_timer_properties
  import cascaded_timer_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        low_clock,
  input wire logic        external_event_input,
  input wire logic        low_speed_mode,
  input wire logic        match_interrupt,
  input wire logic        pwm_output_pin
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite && ce;
  sequence no_rd_s;
    !rd_take;
  endsequence
  // Offsets past the map read as zero
  sequence bad_rd_s;
    rd_take && hsize == SIZE_WORD && haddr[7:0] > OFS_COUNT_STATUS;
  endsequence
  // Narrow reads are refused and leave the last word standing
  sequence narrow_rd_s;
    rd_take && hsize != SIZE_WORD;
  endsequence
  okay_resp_a: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  ready_follows_ce_a: assert property (hreadyout == ce)
    else $error("hreadyout differs from ce");
  reserved_zero_a: assert property (hrdata[31:17] == 15'h0000)
    else $error("reserved read bits set");
  refused_read_a: assert property (bad_rd_s |=> hrdata == 32'h0000_0000)
    else $error("refused read returned data");
  rdata_hold_a: assert property (no_rd_s |=> $stable(hrdata))
    else $error("read data moved without a read");
  narrow_read_a: assert property (narrow_rd_s |=> $stable(hrdata))
    else $error("narrow read changed read data");
  irq_pulse_a: assert property (match_interrupt && ce |=> !match_interrupt)
    else $error("match pulse longer than one cycle");
  reset_quiet_a: assert property ($rose(nrst) |-> pwm_output_pin &&
    !match_interrupt && hrdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");
  frozen_state_a: assert property (!$rose(nrst) &&
    ($changed(pwm_output_pin) || $changed(hrdata)) |-> $past(ce))
    else $error("state moved while clock enable low");
endmodule // cascaded_timer_properties

bind cascaded_16bit_timer_pwm cascaded_timer_properties
  cascaded_timer_properties_inst (.core_clk(core_clk), .nrst(nrst), .ce(ce),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .low_clock(low_clock),
  .external_event_input(external_event_input),
  .low_speed_mode(low_speed_mode), .match_interrupt(match_interrupt),
  .pwm_output_pin(pwm_output_pin));

// [tb/cascaded_16bit_timer_pwm_test.sv]
// Self-checking bench for the cascaded 16-bit timer and PWM
`timescale 1ns/10ps
module cascaded_16bit_timer_pwm_test;
  import cascaded_timer_pkg::*;
  localparam int CYC_LIMIT = 99000;
  // Low clock half period is 10 core cycles, so low/8 is 160 cycles
  localparam int DIVS [6] = '{8, 32, 128, 2048, 160, 160};
  logic        core_clk, nrst, ce, hsel, hwrite, hreadyout, hresp;
  logic        low_clock, ext_in, low_speed_mode, match_interrupt;
  logic        pwm_output_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lc_cnt;
  int          n_errors, n_compared, cycles, n_irq;

  cascaded_16bit_timer_pwm cascaded_16bit_timer_pwm_inst (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .low_clock(low_clock),
    .external_event_input(ext_in), .low_speed_mode(low_speed_mode),
    .match_interrupt(match_interrupt), .pwm_output_pin(pwm_output_pin));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    lc_cnt <= (lc_cnt == 4'h9) ? 4'h0 : lc_cnt + 4'h1;
    if (lc_cnt == 4'h9) low_clock <= ~low_clock;
    if (match_interrupt === 1'b1) n_irq <= n_irq + 1;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == CYC_LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end

  function automatic logic [31:0] exp_gap(int div, int p);
    return 32'(div * p);
  endfunction

  // Ticks over a window of core cycles; low clock period is 20 cycles
  function automatic logic [15:0] exp_steps(int src, int cyc);
    if (src == SRC_LOW) return 16'(cyc / 20);
    else if (src == SRC_HALF) return 16'(cyc / 2);
    else if (src == SRC_FULL) return 16'(cyc);
    return 16'h0005;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (match_interrupt !== 1'b1 && n < 70000);
  endtask

  // Each level held four cycles, above the two-cycle minimum
  task automatic fall();
    repeat (4) @(posedge core_clk);
    ext_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    ext_in <= 1'b1;
  endtask

  initial begin
    logic [31:0] q;
    logic [15:0] d1, d2;
    int          n, k, p;
    {nrst, ce, hsel, hwrite, low_clock, low_speed_mode} = 6'b010000;
    {haddr, hwdata, htrans, lc_cnt} = '0;
    hsize = SIZE_WORD;
    ext_in = 1'b1;
    {n_errors, n_compared, cycles, n_irq} = '0;
    q = $urandom(32'h6037);
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 'h1C; a += 4) rd_chk(8'(a), 32'h0);
    check(pwm_output_pin, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      p = (i < 3) ? 2 + $urandom % 6 : 2;
      low_speed_mode <= (i == 5);
      bus(OFS_LOWER_CTRL, 1'b1, (i < 3) ? 3 - i : SRC_SLOW, q);
      bus(OFS_PERIOD_LOW, 1'b1, p, q);
      bus(OFS_PERIOD_HIGH, 1'b1, 32'h0, q);
      bus(OFS_UPPER_CTRL, 1'b1, (i == 4) ? 8'h18 : 8'h08, q);
      wait_irq(n);
      wait_irq(n);
      check(32'(n), exp_gap(DIVS[i], p));
      bus(OFS_UPPER_CTRL, 1'b1, 32'h0, q);
      rd_chk(OFS_COUNT_STATUS, 32'h0);
    end
    low_speed_mode <= 1'b0;
    $display("test timer done");
    bus(OFS_PERIOD_LOW, 1'b1, 32'h3, q);
    bus(OFS_PERIOD_HIGH, 1'b1, 32'h0, q);
    bus(OFS_UPPER_CTRL, 1'b1, 8'h09, q);
    k = n_irq;
    repeat (7) fall();
    check(32'(n_irq - k), 32'h2);
    rd_chk(OFS_COUNT_STATUS, 32'h1);
    bus(OFS_UPPER_CTRL, 1'b1, 32'h0, q);
    rd_chk(OFS_COUNT_STATUS, 32'h0);
    $display("test event done");
    d1 = 16'h0100 + 16'($urandom % 256);
    d2 = 16'h0800;
    bus(OFS_LOWER_CTRL, 1'b1, SRC_FULL, q);
    bus(OFS_DUTY_LOW, 1'b1, d1[7:0], q);
    bus(OFS_DUTY_HIGH, 1'b1, d1[15:8], q);
    rd_chk(OFS_DUTY_HIGH, d1[15:8]);
    bus(OFS_UPPER_CTRL, 1'b1, 8'h02, q);
    bus(OFS_UPPER_CTRL, 1'b1, 8'h0A, q);
    check(pwm_output_pin, 1'b1);
    repeat (d1 + 20) @(posedge core_clk);
    check(pwm_output_pin, 1'b0);
    bus(OFS_COUNT_STATUS, 1'b0, 32'h0, q);
    check(q[STAT_FF_BIT], 1'b1);
    bus(OFS_DUTY_LOW, 1'b1, d2[7:0], q);
    bus(OFS_DUTY_HIGH, 1'b1, d2[15:8], q);
    rd_chk(OFS_DUTY_HIGH, d1[15:8]);
    ce <= 1'b0;
    repeat (10) @(posedge core_clk);
    ce <= 1'b1;
    wait_irq(n);
    check(pwm_output_pin, 1'b1);
    rd_chk(OFS_DUTY_HIGH, d2[15:8]);
    hsize <= 3'h0;
    rd_chk(OFS_COUNT_STATUS, d2[15:8]);
    hsize <= SIZE_WORD;
    repeat (d2 + 20) @(posedge core_clk);
    check(pwm_output_pin, 1'b0);
    bus(OFS_UPPER_CTRL, 1'b1, 8'h02, q);
    repeat (10) @(posedge core_clk);
    check(pwm_output_pin, 1'b0);
    bus(OFS_UPPER_CTRL, 1'b1, 8'h82, q);
    @(posedge core_clk);
    check(pwm_output_pin, 1'b0);
    bus(OFS_UPPER_CTRL, 1'b1, 8'h02, q);
    @(posedge core_clk);
    check(pwm_output_pin, 1'b1);
    $display("test pwm done");
    // Count advance over 200 cycles, or five pin falls, per PWM source
    for (int j = SRC_LOW; j <= SRC_EXT; j++) begin
      bus(OFS_LOWER_CTRL, 1'b1, j, q);
      bus(OFS_UPPER_CTRL, 1'b1, 8'h0A, q);
      bus(OFS_COUNT_STATUS, 1'b0, 32'h0, q);
      d1 = q[15:0];
      if (j == SRC_EXT) repeat (5) fall();
      else repeat (197) @(posedge core_clk);
      rd_chk(OFS_COUNT_STATUS, d1 + exp_steps(j, 200));
      bus(OFS_UPPER_CTRL, 1'b1, 8'h02, q);
    end
    $display("test source done");
    end_of_test();
  end
endmodule // cascaded_16bit_timer_pwm_test
